// file: hw/iprd_pkg.sv
// package: constants and types for the port read and irq mask executor
package iprd_pkg;
  localparam int IPRD_DATA_W = 16;
  localparam int IPRD_ADDR_W = 16;
  localparam int IPRD_PORT_W = 4;
  localparam int IPRD_DMA_W = 16;
  localparam logic IPRD_MASK_RST = 1'b0;
  localparam logic [15:0] IPRD_ADDR_RST = 16'h0000;
  localparam logic [15:0] IPRD_DATA_RST = 16'h0000;
  // operation codes presented on the start port
  localparam logic [1:0] IPRD_OP_NONE = 2'h0;
  localparam logic [1:0] IPRD_OP_PORT_READ = 2'h1;
  localparam logic [1:0] IPRD_OP_IRQ_DISABLE = 2'h2;
  localparam logic [1:0] IPRD_OP_IRQ_ENABLE = 2'h3;
  // bus sequencer states, one-hot
  typedef enum logic [3:0] {
    IPRD_IDLE = 4'h1,
    IPRD_ADDR = 4'h2,
    IPRD_BUS_STROBE_N = 4'h4,
    IPRD_WRB = 4'h8
  } iprd_state_t;
endpackage : iprd_pkg

// file: hw/iprd_bus_if.sv
// interface: request and answer between the executor and its bus sequencer
`timescale 1ns/1ps
`default_nettype none
interface iprd_bus_if;
  import iprd_pkg::*;
  logic req; // one-cycle start of a port cycle
  logic [IPRD_PORT_W-1:0] port; // selected port
  logic done; // one-cycle end of the cycle
  logic [IPRD_DATA_W-1:0] rdata; // captured word
  modport ctl (output req, output port, input done, input rdata);
  modport seq (input req, input port, output done, output rdata);
endinterface : iprd_bus_if
`default_nettype wire

// file: hw/iprd_bus_seq.sv
// module: external read cycle sequencer shared by i/o port reads
`timescale 1ns/1ps
`default_nettype none
module iprd_bus_seq
  import iprd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  iprd_bus_if.seq bus,
  output logic [IPRD_ADDR_W-1:0] addr,
  output logic bus_strobe_n,
  output logic rd_wr_n,
  output logic io_space_select_n,
  input wire logic bus_ready,
  input wire logic [IPRD_DATA_W-1:0] data_in
);
  iprd_state_t state_ff, nxt_state; // sequencer state
  logic [IPRD_ADDR_W-1:0] addr_ff, nxt_addr; // held address
  logic [IPRD_DATA_W-1:0] rdata_ff, nxt_rdata; // captured word
  logic bus_strobe_n_ff, nxt_bus_strobe_n; // strobe, active low
  logic is_ff, nxt_is; // i/o select, active low
  logic done_ff, nxt_done; // completion pulse

  // port number on low lines, upper lines zero
  wire [IPRD_ADDR_W-1:0] port_addr = {{(IPRD_ADDR_W-IPRD_PORT_W){1'b0}}, bus.port}; // RL6 RL5
  wire sample = (state_ff == IPRD_BUS_STROBE_N) && bus_ready; // ready ends the strobe; waits stretch it

  // next state: same phases as an external data read
  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_rdata = rdata_ff;
    nxt_bus_strobe_n = bus_strobe_n_ff;
    nxt_is = is_ff;
    nxt_done = 1'b0;
    case (state_ff)
      IPRD_IDLE: begin
        if (bus.req) begin
          // address and select settle one cycle before strobe
          nxt_addr = port_addr; // RL5
          nxt_is = 1'b0; // RL2
          nxt_state = IPRD_ADDR;
        end
      end
      IPRD_ADDR: begin
        nxt_bus_strobe_n = 1'b0; // RL3
        nxt_state = IPRD_BUS_STROBE_N;
      end
      IPRD_BUS_STROBE_N: begin
        if (sample) begin
          nxt_rdata = data_in; // RL1
          nxt_bus_strobe_n = 1'b1;
          nxt_state = IPRD_WRB;
        end
      end
      IPRD_WRB: begin
        // select released after strobe rises
        nxt_is = 1'b1;
        nxt_addr = IPRD_ADDR_RST;
        nxt_done = 1'b1;
        nxt_state = IPRD_IDLE;
      end
      default: nxt_state = IPRD_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= IPRD_IDLE;
      addr_ff <= IPRD_ADDR_RST;
      rdata_ff <= IPRD_DATA_RST;
      bus_strobe_n_ff <= 1'b1;
      is_ff <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      rdata_ff <= nxt_rdata;
      bus_strobe_n_ff <= nxt_bus_strobe_n;
      is_ff <= nxt_is;
      done_ff <= nxt_done;
    end
  end

  assign addr = addr_ff;
  assign bus_strobe_n = bus_strobe_n_ff;
  assign rd_wr_n = 1'b1; // always a read cycle
  assign io_space_select_n = is_ff;
  assign bus.done = done_ff;
  assign bus.rdata = rdata_ff;
endmodule : iprd_bus_seq
`default_nettype wire

// file: hw/iprd_exec.sv
// module: executor for the port read and irq disable operations
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RL1 - port read stores 16-bit word in memory
// RL2 - io select low during port read
// RL3 - handshake same as external data read
// RL4 - irq disable sets global mask flag
// RL5 - port number 0..15 presented on bus
// RL6 - port on low lines, upper lines zero
module iprd_exec
  import iprd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire logic [1:0] op_code,
  input wire logic [IPRD_PORT_W-1:0] port_number,
  input wire logic [IPRD_DMA_W-1:0] op_dma,
  output logic op_ready,
  output logic op_done,
  output logic [IPRD_ADDR_W-1:0] addr,
  output logic bus_strobe_n,
  output logic rd_wr_n,
  output logic io_space_select_n,
  input wire logic bus_ready,
  input wire logic [IPRD_DATA_W-1:0] data_in,
  output logic dmem_we,
  output logic [IPRD_DMA_W-1:0] dmem_addr,
  output logic [IPRD_DATA_W-1:0] dmem_wdata,
  output logic global_irq_mask_flag,
  input wire logic irq_req,
  output logic irq_take
);
  iprd_bus_if bus_i ();

  logic busy_ff, nxt_busy; // port read in flight
  logic [IPRD_DMA_W-1:0] dma_ff, nxt_dma; // destination address
  logic mask_ff, nxt_mask; // global mask
  logic we_ff, nxt_we; // memory write pulse
  logic [IPRD_DATA_W-1:0] wdata_ff, nxt_wdata; // memory write data
  logic done_ff, nxt_done; // completion pulse
  logic irq_take_ff, nxt_irq_take; // interrupt accepted

  // operation decode
  wire accept = op_valid && !busy_ff;
  wire start_rd = accept && (op_code == IPRD_OP_PORT_READ);
  wire do_irq_disable_op = accept && (op_code == IPRD_OP_IRQ_DISABLE);
  wire do_eint = accept && (op_code == IPRD_OP_IRQ_ENABLE);
  wire single = do_irq_disable_op || do_eint || (accept && (op_code == IPRD_OP_NONE));

  assign bus_i.req = start_rd;
  assign bus_i.port = port_number; // RL5

  iprd_bus_seq u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .bus(bus_i),
    .addr(addr),
    .bus_strobe_n(bus_strobe_n),
    .rd_wr_n(rd_wr_n),
    .io_space_select_n(io_space_select_n),
    .bus_ready(bus_ready),
    .data_in(data_in)
  );

  // next values for control, mask and memory write
  always_comb begin
    nxt_busy = busy_ff;
    nxt_dma = dma_ff;
    nxt_mask = mask_ff;
    nxt_we = 1'b0;
    nxt_wdata = wdata_ff;
    nxt_done = 1'b0;
    // mask only gates maskable requests; none taken while set
    nxt_irq_take = irq_req && !mask_ff && !busy_ff; // RL4
    if (start_rd) begin
      nxt_busy = 1'b1;
      nxt_dma = op_dma;
    end
    if (do_irq_disable_op) begin
      nxt_mask = 1'b1; // RL4
    end else if (do_eint) begin
      nxt_mask = 1'b0;
    end
    if (single) begin
      nxt_done = 1'b1;
    end
    if (busy_ff && bus_i.done) begin
      // word arrives from sequencer, write to data memory
      nxt_we = 1'b1; // RL1
      nxt_wdata = bus_i.rdata; // RL1
      nxt_busy = 1'b0;
      nxt_done = 1'b1;
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      dma_ff <= '0;
      mask_ff <= IPRD_MASK_RST;
      we_ff <= 1'b0;
      wdata_ff <= IPRD_DATA_RST;
      done_ff <= 1'b0;
      irq_take_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
      dma_ff <= nxt_dma;
      mask_ff <= nxt_mask;
      we_ff <= nxt_we;
      wdata_ff <= nxt_wdata;
      done_ff <= nxt_done;
      irq_take_ff <= nxt_irq_take;
    end
  end

  assign op_ready = !busy_ff; // one operation at a time
  assign op_done = done_ff;
  assign dmem_we = we_ff;
  assign dmem_addr = dma_ff;
  assign dmem_wdata = wdata_ff;
  assign global_irq_mask_flag = mask_ff;
  assign irq_take = irq_take_ff;
endmodule : iprd_exec
`default_nettype wire

// file: test/iprd_asserts.sv
// checker: bus cycle and mask relations at the executor ports
`timescale 1ns/1ps
`default_nettype none
module iprd_asserts
  import iprd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire logic op_done,
  input wire logic [1:0] op_code,
  input wire logic [IPRD_PORT_W-1:0] port_number,
  input wire logic [IPRD_ADDR_W-1:0] addr,
  input wire logic bus_strobe_n,
  input wire logic io_space_select_n,
  input wire logic bus_ready,
  input wire logic global_irq_mask_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_bus_strobe_n_io_sel: assert property (!bus_strobe_n |-> !io_space_select_n)
    else $error("strobe without io select");
  chk_addr_high_zero: assert property (!io_space_select_n |-> addr[15:4] == 12'h000)
    else $error("upper address lines set");
  chk_bus_strobe_n_end: assert property (!bus_strobe_n && bus_ready |=> bus_strobe_n)
    else $error("strobe held after ready");
  chk_wait_hold: assert property (!bus_strobe_n && !bus_ready |=> !bus_strobe_n)
    else $error("strobe dropped in wait");
  chk_port_addr: assert property (op_valid && op_ready && op_code == IPRD_OP_PORT_READ
    |=> addr == {12'h000, $past(port_number)} && !io_space_select_n)
    else $error("port number not on bus");
  chk_mask_set: assert property (op_valid && op_ready && op_code == IPRD_OP_IRQ_DISABLE
    |=> global_irq_mask_flag && op_done)
    else $error("mask not set");
  // main scenarios: a read, a wait state, a mask change
  cover property (!bus_strobe_n && bus_ready);
  cover property (!bus_strobe_n && !bus_ready);
  cover property ($rose(global_irq_mask_flag));
endmodule : iprd_asserts
bind iprd_exec iprd_asserts i_chk (.*);
`default_nettype wire

// file: test/iprd_periph.sv
// partner: io peripheral answering port reads with wait states
`timescale 1ns/1ps
`default_nettype none
module iprd_periph (
  input wire logic clk,
  input wire logic bus_strobe_n,
  input wire logic io_space_select_n,
  input wire logic [15:0] addr,
  input wire logic [3:0] waits,
  output logic bus_ready,
  output logic [15:0] data_in
);
  logic [3:0] cnt_ff; // strobe cycles seen
  logic [15:0] last_ff; // last word driven
  wire sel = !bus_strobe_n && !io_space_select_n;
  // count strobe cycles so ready can lag by the wait count
  always_ff @(posedge clk) begin
    cnt_ff <= sel ? cnt_ff + 4'h1 : 4'h0;
    last_ff <= data_in;
  end
  // ready after exactly waits strobe cycles; zero waits answers at once
  assign bus_ready = sel && cnt_ff >= waits;
  // released bus alternates between the last word and its inverse
  assign data_in = sel ? {12'hC30, addr[3:0]} : ~last_ff;
endmodule : iprd_periph
`default_nettype wire

// file: test/tb_top.sv
// testbench: executor against the peripheral model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import iprd_pkg::*;
  typedef struct packed {logic [1:0] op; logic [3:0] p; logic [3:0] w;} iprd_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  logic irq_req = 1'b0;
  logic [1:0] op_code = 2'h0;
  logic [3:0] port_number = 4'h0;
  logic [3:0] waits = 4'h0;
  logic [15:0] op_dma = 16'h0000;
  logic op_ready, op_done, bus_strobe_n, rd_wr_n, io_space_select_n, bus_ready;
  logic dmem_we, global_irq_mask_flag, irq_take;
  logic [15:0] addr, data_in, dmem_addr, dmem_wdata;
  logic exp_mask = 1'b0;
  int n_mismatch = 0;
  int checked = 0;
  int n;
  iprd_row_t rows [6] = '{'{2'h1, 4'h0, 4'h0}, '{2'h1, 4'hF, 4'h3}, '{2'h2, 4'h0, 4'h0},
    '{2'h0, 4'h0, 4'h0}, '{2'h1, 4'h5, 4'h1}, '{2'h3, 4'h0, 4'h0}};
  always #12.5 clk = ~clk;
  iprd_exec i_dut (.*);
  iprd_periph i_per (.*);
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task summarize;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // wait for completion, bounded
  task wait_done;
    n = 0;
    #1;
    while (op_done !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_done
  initial begin
    repeat (10) @(posedge clk);
    #1;
    chk({bus_strobe_n, io_space_select_n, op_ready, global_irq_mask_flag}, 16'h000E);
    @(posedge clk) rst_n <= 1'b1;
    foreach (rows[i]) begin
      @(posedge clk);
      {op_valid, op_code, port_number, waits, op_dma} <= {1'b1, rows[i], 16'h0040 + 16'(i)};
      @(posedge clk) op_valid <= 1'b0;
      wait_done();
      exp_mask = rows[i].op == IPRD_OP_IRQ_DISABLE ? 1'b1 : rows[i].op == 2'h3 ? 1'b0 : exp_mask;
      chk(op_done, 1'b1);
      chk(global_irq_mask_flag, exp_mask);
      chk(dmem_we, rows[i].op == IPRD_OP_PORT_READ);
      if (rows[i].op == IPRD_OP_PORT_READ) chk(dmem_wdata, {12'hC30, rows[i].p});
      if (rows[i].op == IPRD_OP_PORT_READ) chk(dmem_addr, 16'h0040 + 16'(i));
    end
    // disable request while a read is busy must be refused
    @(posedge clk) {op_valid, op_code, port_number, waits} <= {1'b1, IPRD_OP_PORT_READ, 8'h92};
    @(posedge clk) op_code <= IPRD_OP_IRQ_DISABLE;
    repeat (3) @(posedge clk);
    op_valid <= 1'b0;
    wait_done();
    chk(global_irq_mask_flag, 1'b0);
    chk(dmem_wdata, 16'hC309);
    // back to back disable then enable
    @(posedge clk) {op_valid, op_code} <= {1'b1, IPRD_OP_IRQ_DISABLE};
    @(posedge clk) op_code <= 2'h3;
    #1 chk(global_irq_mask_flag, 1'b1);
    @(posedge clk) op_valid <= 1'b0;
    #1 chk(global_irq_mask_flag, 1'b0);
    // maskable request taken while clear, refused once the mask is set
    @(posedge clk) irq_req <= 1'b1;
    @(posedge clk) {op_valid, op_code} <= {1'b1, IPRD_OP_IRQ_DISABLE};
    #1 chk(irq_take, 1'b1);
    @(posedge clk) op_valid <= 1'b0;
    @(posedge clk);
    #1 chk(irq_take, 1'b0);
    chk(rd_wr_n, 1'b1);
    // reset in mid-run clears the mask
    @(posedge clk) rst_n <= 1'b0;
    irq_req <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(global_irq_mask_flag, 1'b0);
    chk({bus_strobe_n, io_space_select_n, op_ready}, 16'h0007);
    summarize();
  end
  initial begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
